// File: hw/cbt_channel_bus.sv
`timescale 1ns/1ps
// Operation
// R1: Rank one loads on strobe with odd enable
// R2: Rank one input is bus-in or diagnostic loopback
// R3: Parity line selects even or odd check
// R4: Flag error unless nine lines odd
// R5: Rank two loads only on rank-two strobe
// R6: Rank two readable on byte one, select clear
// R7: Assembly option widens register, odd flag picks half
// R8: Odd flag set, toggles only in assembly transfers
// R9: Assembly transfers put sixteen bits on input bus
// R10: High bus-out byte loops back in assembly diagnostics
// R11: Tag-out loads inverted byte one on select bit
// R12: Fixed tag-out bit positions, bit 15 unused
// R13: Tag bits drive adapters and external transmitters
// R14: Tag-out readable on byte one when selected
// R15: Address-out marks bus-out as device address
// R16: Command-out meaning depends on answered tag
// R17: Service-out only answers service-in or status-in
// R18: Control logic or register may assert command/service/data
// R19: Outgoing signals meaningful only with operational-out
// R20: Select-out chains through fitted adapters in order
// R21: Hold-out follows select-out, 4 us lockout
// R22: Far units gate select with hold, clear on drop
// R23: Data-out answers data-in for equipped units only
// R24: Rank one loads only for input direction; the code also loads it while diagnostic loopback is active
// R25: Diagnostic without operational/suppress loops bus-out back
// R26: Parity error latched only when no adapter selected
// R27: Lockout is a restarted down-counter
module cbt_channel_bus #(
    parameter bit ASSEMBLY_OPTION = 1'b0,
    parameter int LOCKOUT_CYCLES = cbt_pkg::HOLD_LOCKOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Extended register access from microcode
    input wire logic [3:0] ext_reg_group3_select,
    input wire logic write_register_pulse,
    input wire logic [15:0] ext_reg_output_bus,
    output logic [15:0] ext_reg_input_bus,
    // Channel control register state used here
    input wire logic ccr_input_dir,
    input wire logic ccr_diagnostic,
    input wire logic ccr_assembly_mode,
    // Channel control logic strobes and tag drives
    input wire logic rank_one_load_strobe,
    input wire logic rank_two_strobe,
    input wire logic data_transfer_seq,
    input wire logic byte_transferred,
    input wire logic ctl_command_out,
    input wire logic ctl_service_out,
    input wire logic ctl_data_out,
    input wire logic unit_has_data_pair,
    // Bus-out second rank (inverted levels as driven to the line)
    input wire logic [15:0] bus_out_rank_two,
    // Bus-in side
    input wire logic [7:0] bus_in_lines,
    input wire logic bus_in_parity,
    input wire logic adapter_selected,
    input wire logic service_in_tag,
    input wire logic status_in_tag,
    input wire logic data_in_tag,
    input wire logic [7:0] tag_in_lines,
    // Selection loop
    input wire logic card_reader_adapter_present,
    input wire logic reader_punch_adapter_present,
    input wire logic external_interface_present,
    input wire logic ext_select_in,
    input wire logic card_reader_select_in,
    input wire logic reader_punch_select_in,
    input wire logic operational_in_tag,
    output logic ext_select_out,
    output logic card_reader_select_out,
    output logic reader_punch_select_out,
    output logic select_in_tag,
    // Tag-out lines
    output logic address_out_tag,
    output logic command_out_tag,
    output logic service_out_tag,
    output logic operational_out_tag,
    output logic hold_out_tag,
    output logic suppress_out_tag,
    output logic data_out_tag,
    output logic [7:0] diag_tag_in,
    output logic diag_loop_active,
    output logic channel_parity_error_flag,
    output logic transmission_check,
    output logic odd_byte,
    output logic hold_lockout_busy
);
    logic [15:0] bus_in_rank_one;
    logic [15:0] next_bus_in_rank_one;
    logic [15:0] bus_in_rank_two;
    logic [15:0] next_bus_in_rank_two;
    logic [7:0] tag_out_register;
    logic [7:0] next_tag_out_register;
    logic next_odd_byte;
    logic next_transmission_check;
    logic [7:0] rank_one_source;
    logic assembly_active;
    logic select_out;

    // Odd parity test over the byte plus its parity bit
    function automatic logic odd_ones(input logic [7:0] b, input logic p);
        odd_ones = ^{b, p};
    endfunction

    // Diagnostic loopback enable and rank one input selection
    assign assembly_active = ASSEMBLY_OPTION && ccr_assembly_mode;
    assign diag_loop_active = ccr_diagnostic
        && !tag_out_register[cbt_pkg::TAG_OPERATIONAL]
        && !tag_out_register[cbt_pkg::TAG_SUPPRESS]; // [R25]
    always_comb begin
        rank_one_source = bus_in_lines; // [R2]
        if (diag_loop_active) begin
            if (assembly_active && !odd_byte) begin
                rank_one_source = ~bus_out_rank_two[15:8]; // [R10]
            end else begin
                rank_one_source = ~bus_out_rank_two[7:0]; // [R2]
            end
        end
    end
    assign diag_tag_in = diag_loop_active ? ~bus_out_rank_two[7:0] : 8'h00; // [R25]
    // Checker mode: parity 1 means even data, 0 means odd data
    assign channel_parity_error_flag = !odd_ones(bus_in_lines, bus_in_parity); // [R3] [R4]

    // Bus-in ranks, odd byte flag and transmission check next values
    always_comb begin
        next_bus_in_rank_one = bus_in_rank_one;
        next_bus_in_rank_two = bus_in_rank_two;
        next_odd_byte = odd_byte;
        next_transmission_check = transmission_check;
        if (rank_one_load_strobe && (ccr_input_dir || diag_loop_active)) begin // [R24]
            if (!ASSEMBLY_OPTION || odd_byte) begin
                next_bus_in_rank_one[15:8] = rank_one_source; // [R1] [R7]
            end else begin
                next_bus_in_rank_one[7:0] = rank_one_source; // [R7]
            end
            if (!adapter_selected && channel_parity_error_flag) begin
                next_transmission_check = 1'b1; // [R26]
            end
        end else if (command_out_tag || service_out_tag) begin
            next_transmission_check = 1'b0;
        end
        if (rank_two_strobe) begin
            next_bus_in_rank_two = bus_in_rank_one; // [R5]
        end
        if (!data_transfer_seq || !assembly_active) begin
            next_odd_byte = 1'b1; // [R8]
        end else if (byte_transferred) begin
            next_odd_byte = !odd_byte; // [R8]
        end
    end

    // Tag-out register write, stored inverted from byte one
    always_comb begin
        next_tag_out_register = tag_out_register;
        if (write_register_pulse && ext_reg_group3_select[cbt_pkg::SEL_BIT_TOR]) begin
            next_tag_out_register = ~ext_reg_output_bus[15:8]; // [R11]
            next_tag_out_register[cbt_pkg::TAG_UNUSED] = 1'b0; // [R12]
        end
    end

    // Register state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_in_rank_one <= {cbt_pkg::BUS_IN_RESET, cbt_pkg::BUS_IN_RESET};
            bus_in_rank_two <= {cbt_pkg::BUS_IN_RESET, cbt_pkg::BUS_IN_RESET};
            tag_out_register <= cbt_pkg::TAG_OUT_RESET;
            odd_byte <= 1'b1;
            transmission_check <= 1'b0;
        end else if (clk_en) begin
            bus_in_rank_one <= next_bus_in_rank_one;
            bus_in_rank_two <= next_bus_in_rank_two;
            tag_out_register <= next_tag_out_register;
            odd_byte <= next_odd_byte;
            transmission_check <= next_transmission_check;
        end
    end

    // Readback onto the extended register input bus
    always_comb begin
        ext_reg_input_bus = 16'h0000;
        case (ext_reg_group3_select[3:2])
            2'b00: begin
                ext_reg_input_bus[15:8] = bus_in_rank_two[15:8]; // [R6]
                if (assembly_active && data_transfer_seq) begin
                    ext_reg_input_bus[7:0] = bus_in_rank_two[7:0]; // [R9]
                end
            end
            2'b10: begin
                ext_reg_input_bus[15:8] = tag_out_register; // [R14]
                ext_reg_input_bus[7:0] = tag_in_lines;
            end
            default: ext_reg_input_bus = 16'h0000;
        endcase
    end

    // Tag-out line drive; control logic ORs into command, service, data
    assign address_out_tag = tag_out_register[cbt_pkg::TAG_ADDRESS]; // [R13] [R15]
    assign operational_out_tag = tag_out_register[cbt_pkg::TAG_OPERATIONAL]; // [R19]
    assign suppress_out_tag = tag_out_register[cbt_pkg::TAG_SUPPRESS]; // [R13]
    assign command_out_tag = tag_out_register[cbt_pkg::TAG_COMMAND] || ctl_command_out; // [R18] [R16]
    assign service_out_tag = tag_out_register[cbt_pkg::TAG_SERVICE]
        || (ctl_service_out && (service_in_tag || status_in_tag)); // [R17] [R18]
    assign data_out_tag = tag_out_register[cbt_pkg::TAG_DATA]
        || (ctl_data_out && data_in_tag && unit_has_data_pair); // [R23] [R18]
    assign select_out = tag_out_register[cbt_pkg::TAG_SELECT];

    // Serial selection loop: external, card reader, reader-punch, return
    always_comb begin
        logic chain;
        chain = 1'b0;
        ext_select_out = select_out && external_interface_present; // [R20]
        chain = external_interface_present ? ext_select_in : select_out;
        card_reader_select_out = card_reader_adapter_present && chain;
        if (card_reader_adapter_present) begin
            chain = card_reader_select_in;
        end
        reader_punch_select_out = reader_punch_adapter_present && chain;
        if (reader_punch_adapter_present) begin
            chain = reader_punch_select_in;
        end
        select_in_tag = chain && !operational_in_tag; // [R20]
    end

    // Hold-out with lockout timer
    cbt_hold_ctrl #(
        .LOCKOUT_CYCLES(LOCKOUT_CYCLES)
    ) u_hold (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .select_out(select_out),
        .hold_out_tag(hold_out_tag),
        .lockout_busy(hold_lockout_busy)
    );
endmodule

// File: hw/cbt_hold_ctrl.sv
`timescale 1ns/1ps
// Hold-out generation with lockout after each select-out fall
module cbt_hold_ctrl #(
    parameter int LOCKOUT_CYCLES = cbt_pkg::HOLD_LOCKOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic select_out,
    output logic hold_out_tag,
    output logic lockout_busy
);
    localparam int TW = $clog2(LOCKOUT_CYCLES + 1);
    localparam logic [TW-1:0] LOAD = TW'(LOCKOUT_CYCLES);

    cbt_pkg::cbt_hold_state_t state;
    cbt_pkg::cbt_hold_state_t next_state;
    logic [TW-1:0] hold_lockout_timer;
    logic [TW-1:0] next_hold_lockout_timer;

    // Next state: hold follows select, then counts down before rearming
    always_comb begin
        next_state = state;
        next_hold_lockout_timer = hold_lockout_timer;
        case (state)
            cbt_pkg::CBT_HOLD_IDLE: begin
                if (select_out) begin
                    next_state = cbt_pkg::CBT_HOLD_ACTIVE; // [R21]
                end
            end
            cbt_pkg::CBT_HOLD_ACTIVE: begin
                if (!select_out) begin
                    next_state = cbt_pkg::CBT_HOLD_LOCKOUT; // [R21]
                    next_hold_lockout_timer = LOAD; // [R27]
                end
            end
            cbt_pkg::CBT_HOLD_LOCKOUT: begin
                if (hold_lockout_timer <= TW'(1)) begin
                    next_hold_lockout_timer = '0;
                    next_state = cbt_pkg::CBT_HOLD_IDLE;
                end else begin
                    next_hold_lockout_timer = hold_lockout_timer - TW'(1); // [R27]
                end
            end
            default: begin
                next_state = cbt_pkg::CBT_HOLD_IDLE;
                next_hold_lockout_timer = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= cbt_pkg::CBT_HOLD_IDLE;
            hold_lockout_timer <= '0;
        end else if (clk_en) begin
            state <= next_state;
            hold_lockout_timer <= next_hold_lockout_timer;
        end
    end

    // Hold-out stands only while select is up and not locked out
    assign hold_out_tag = (state == cbt_pkg::CBT_HOLD_ACTIVE) && select_out; // [R21]
    assign lockout_busy = (state == cbt_pkg::CBT_HOLD_LOCKOUT);
endmodule

// File: hw/cbt_pkg.sv
package cbt_pkg;
    // Extended register group select bits (index into 4-bit select)
    localparam int SEL_BIT_BCR = 0;
    localparam int SEL_BIT_BOR = 1;
    localparam int SEL_BIT_CCR = 2;
    localparam int SEL_BIT_TOR = 3;
    // Tag-out register bit positions within input/output bus byte one
    localparam int TAG_ADDRESS = 0;
    localparam int TAG_COMMAND = 1;
    localparam int TAG_SERVICE = 2;
    localparam int TAG_OPERATIONAL = 3;
    localparam int TAG_SELECT = 4;
    localparam int TAG_SUPPRESS = 5;
    localparam int TAG_DATA = 6;
    localparam int TAG_UNUSED = 7;
    // Byte field positions on the 16-bit buses
    localparam int BYTE_ONE_LSB = 8;
    localparam int BYTE_ZERO_LSB = 0;
    // Reset values
    localparam logic [7:0] TAG_OUT_RESET = 8'h00;
    localparam logic [7:0] BUS_IN_RESET = 8'h00;
    // Hold-out lockout timing
    localparam int HOLD_LOCKOUT_NS = 4000;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HOLD_LOCKOUT_CYCLES = (HOLD_LOCKOUT_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int HOLD_TIMER_WIDTH = $clog2(HOLD_LOCKOUT_CYCLES + 1);
    // Hold-out control states
    typedef enum logic [2:0] {
        CBT_HOLD_IDLE = 3'b001,
        CBT_HOLD_ACTIVE = 3'b010,
        CBT_HOLD_LOCKOUT = 3'b100
    } cbt_hold_state_t;
endpackage

// File: sim/cbt_channel_bus_tb_top.sv
`timescale 1ns/1ps
module cbt_channel_bus_tb_top;
    logic clk = 0, rst = 1, clk_en = 0, write_register_pulse = 0, ccr_input_dir = 0;
    logic ccr_diagnostic = 0, ccr_assembly_mode = 0, rank_one_load_strobe = 0;
    logic rank_two_strobe = 0, data_transfer_seq = 0, byte_transferred = 0;
    logic ctl_command_out = 0, ctl_service_out = 0, ctl_data_out = 0, unit_has_data_pair = 0;
    logic adapter_selected = 0, service_in_tag = 0, status_in_tag = 0, data_in_tag = 0;
    logic card_reader_adapter_present = 1, reader_punch_adapter_present = 0;
    logic external_interface_present = 0, ext_select_in = 0, operational_in_tag = 0;
    logic reader_punch_select_in = 0, offer = 0, bad_par = 0;
    logic [3:0] ext_reg_group3_select = 4'h0;
    logic [15:0] ext_reg_output_bus = 16'hFFFF, bus_out_rank_two = 16'h0000, ext_reg_input_bus;
    logic [7:0] tag_in_lines = 8'h00, tx_byte = 8'h00, exp_tor = 8'h00, bus_in_lines, diag_tag_in;
    logic ext_select_out, card_reader_select_out, reader_punch_select_out, select_in_tag;
    logic address_out_tag, command_out_tag, service_out_tag, operational_out_tag, hold_out_tag;
    logic suppress_out_tag, data_out_tag, diag_loop_active, bus_in_parity, card_reader_select_in;
    logic channel_parity_error_flag, transmission_check, odd_byte, hold_lockout_busy;
    logic [15:0] exp_r1 = 16'h0000;
    int err_count = 0, checked = 0, cyc = 0, exp_odd = 1, exp_xmn = 0, n;
    cbt_channel_bus #(.ASSEMBLY_OPTION(1'b1), .LOCKOUT_CYCLES(8)) dut (
        .clk(clk), .rst(rst), .clk_en(clk_en),
        .ext_reg_group3_select(ext_reg_group3_select),
        .write_register_pulse(write_register_pulse),
        .ext_reg_output_bus(ext_reg_output_bus), .ext_reg_input_bus(ext_reg_input_bus),
        .ccr_input_dir(ccr_input_dir), .ccr_diagnostic(ccr_diagnostic),
        .ccr_assembly_mode(ccr_assembly_mode), .rank_one_load_strobe(rank_one_load_strobe),
        .rank_two_strobe(rank_two_strobe), .data_transfer_seq(data_transfer_seq),
        .byte_transferred(byte_transferred), .ctl_command_out(ctl_command_out),
        .ctl_service_out(ctl_service_out), .ctl_data_out(ctl_data_out),
        .unit_has_data_pair(unit_has_data_pair), .bus_out_rank_two(bus_out_rank_two),
        .bus_in_lines(bus_in_lines), .bus_in_parity(bus_in_parity),
        .adapter_selected(adapter_selected), .service_in_tag(service_in_tag),
        .status_in_tag(status_in_tag), .data_in_tag(data_in_tag), .tag_in_lines(tag_in_lines),
        .card_reader_adapter_present(card_reader_adapter_present),
        .reader_punch_adapter_present(reader_punch_adapter_present),
        .external_interface_present(external_interface_present), .ext_select_in(ext_select_in),
        .card_reader_select_in(card_reader_select_in),
        .reader_punch_select_in(reader_punch_select_in),
        .operational_in_tag(operational_in_tag),
        .ext_select_out(ext_select_out), .card_reader_select_out(card_reader_select_out),
        .reader_punch_select_out(reader_punch_select_out), .select_in_tag(select_in_tag),
        .address_out_tag(address_out_tag), .command_out_tag(command_out_tag),
        .service_out_tag(service_out_tag), .operational_out_tag(operational_out_tag),
        .hold_out_tag(hold_out_tag), .suppress_out_tag(suppress_out_tag),
        .data_out_tag(data_out_tag), .diag_tag_in(diag_tag_in),
        .diag_loop_active(diag_loop_active),
        .channel_parity_error_flag(channel_parity_error_flag),
        .transmission_check(transmission_check), .odd_byte(odd_byte),
        .hold_lockout_busy(hold_lockout_busy));
    cbt_far_end far (.clk(clk), .offer(offer), .tx_byte(tx_byte), .bad_par(bad_par),
        .hold_out_tag(hold_out_tag), .card_reader_select_out(card_reader_select_out),
        .bus_in_lines(bus_in_lines), .bus_in_parity(bus_in_parity),
        .card_reader_select_in(card_reader_select_in));
    // Clock and hang limit
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Register write, then readback of tag-out with tag-in lines
    task automatic wr_tor(input logic [15:0] d, input logic s3);
        @(posedge clk);
        {ext_reg_group3_select, ext_reg_output_bus, write_register_pulse} <= {s3, 3'h0, d, 1'b1};
        @(posedge clk);
        {ext_reg_group3_select, write_register_pulse} <= 5'h10;
        exp_tor = s3 ? ~d[15:8] & 8'h7F : exp_tor;
        @(negedge clk);
        chk("tor_rd", ext_reg_input_bus, {exp_tor, tag_in_lines});
    endtask
    // One bus-in byte through both ranks, then readback
    task automatic take(input logic [7:0] b, input logic bad, input logic asel);
        @(posedge clk);
        {offer, tx_byte, bad_par, adapter_selected, rank_one_load_strobe} <= {1'b1, b, bad, asel, 1'b1};
        ext_reg_group3_select <= 4'h0;
        @(negedge clk);
        chk("par_flag", 16'(channel_parity_error_flag), 16'(bad));
        b = diag_loop_active ? ~bus_out_rank_two[7:0] : b;
        if (ccr_input_dir || diag_loop_active) begin
            exp_r1 = exp_odd != 0 ? {b, exp_r1[7:0]} : {exp_r1[15:8], b};
            exp_xmn = exp_xmn | (bad & !asel);
        end
        @(posedge clk);
        {offer, rank_one_load_strobe, rank_two_strobe} <= 3'b001;
        byte_transferred <= data_transfer_seq;
        @(posedge clk);
        {rank_two_strobe, byte_transferred} <= 2'b00;
        exp_odd = (data_transfer_seq && ccr_assembly_mode) ? 1 - exp_odd : exp_odd;
        @(negedge clk);
        chk("odd_byte", 16'(odd_byte), 16'(exp_odd));
        chk("xmn", 16'(transmission_check), 16'(exp_xmn));
        if (data_transfer_seq)
            chk("bus_in16", ext_reg_input_bus, exp_r1);
        else
            chk("bus_in8", 16'(ext_reg_input_bus[15:8]), 16'(exp_r1[15:8]));
    endtask
    // Main sequence
    initial begin
        n = $urandom(32'h6504a11a);
        repeat (3) @(posedge clk);
        {rst, clk_en} <= 2'b01;
        @(negedge clk);
        chk("odd_rst", 16'(odd_byte), 16'h0001);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {tag_in_lines, ccr_diagnostic} <= 9'($urandom);
            wr_tor(16'($urandom) | 16'h1000, i != 0);
            chk("diag", 16'(diag_loop_active), 16'(ccr_diagnostic & ~exp_tor[3] & ~exp_tor[5]));
        end
        $display("register test done");
        @(posedge clk);
        {ccr_diagnostic, ccr_input_dir} <= 2'b01;
        wr_tor(16'hFFFF, 1'b1);
        for (int i = 0; i < 4; i++)
            take(8'($urandom), i[0], i[1]);
        @(posedge clk);
        {ccr_input_dir, ccr_diagnostic, bus_out_rank_two} <= {2'b00, 16'($urandom)};
        take(8'h5A, 1'b1, 1'b0);
        @(posedge clk);
        ccr_diagnostic <= 1'b1;
        take(8'h3C, 1'b0, 1'b0);
        chk("diag_tag", 16'(diag_tag_in), {8'h00, ~bus_out_rank_two[7:0]});
        @(posedge clk);
        {ccr_diagnostic, ccr_input_dir, ccr_assembly_mode, data_transfer_seq} <= 4'b0111;
        repeat (4) take(8'($urandom), 1'b0, 1'b0);
        $display("bus-in test done");
        wr_tor(16'hEFFF, 1'b1);
        @(negedge clk);
        chk("hold_up", 16'({hold_out_tag, select_in_tag}), 16'h0003);
        // Fit the external interface and reader-punch; loop returns open at the last unit
        @(posedge clk);
        {external_interface_present, reader_punch_adapter_present, ext_select_in} <= 3'b111;
        @(negedge clk);
        chk("loop", 16'({ext_select_out, card_reader_select_out,
            reader_punch_select_out, select_in_tag}), 16'h000E);
        wr_tor(16'hFFFF, 1'b1);
        chk("hold_dn", 16'(hold_out_tag), 16'h0000);
        wr_tor(16'hEFFF, 1'b1);
        for (n = 0; hold_out_tag !== 1'b1 && n < 40; n++)
            @(negedge clk);
        chk("lockout", 16'(n >= 6 && n <= 12), 16'h0001);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {service_in_tag, status_in_tag, data_in_tag, operational_in_tag} <= 4'hF;
            {ctl_command_out, ctl_service_out, ctl_data_out, unit_has_data_pair} <= {3'h7, i[0]};
            @(negedge clk);
            chk("sel_in_opl", 16'(select_in_tag), 16'h0000);
            chk("ctl", 16'({command_out_tag, service_out_tag, data_out_tag}), 16'({2'b11, i[0]}));
        end
        $display("tag test done");
        end_sim();
    end
endmodule

// File: sim/cbt_chk.sv
`timescale 1ns/1ps
module cbt_chk #(
    parameter int LOCKOUT_CYCLES = cbt_pkg::HOLD_LOCKOUT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [3:0] ext_reg_group3_select,
    input wire logic write_register_pulse,
    input wire logic [15:0] ext_reg_output_bus,
    input wire logic ccr_input_dir,
    input wire logic ccr_diagnostic,
    input wire logic ccr_assembly_mode,
    input wire logic rank_one_load_strobe,
    input wire logic data_transfer_seq,
    input wire logic byte_transferred,
    input wire logic [7:0] bus_in_lines,
    input wire logic bus_in_parity,
    input wire logic adapter_selected,
    input wire logic address_out_tag,
    input wire logic operational_out_tag,
    input wire logic suppress_out_tag,
    input wire logic hold_out_tag,
    input wire logic diag_loop_active,
    input wire logic channel_parity_error_flag,
    input wire logic transmission_check,
    input wire logic odd_byte,
    input wire logic hold_lockout_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Accepted tag-out write, and the fall of hold-out
    sequence s_wr_tor;
        clk_en && write_register_pulse && ext_reg_group3_select[3];
    endsequence
    sequence s_drop;
        $fell(hold_out_tag);
    endsequence
    // Cycles hold-out has stood low, saturating at the lockout length
    int low_run;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_run <= LOCKOUT_CYCLES;
        else if (hold_out_tag)
            low_run <= 0;
        else if (low_run < LOCKOUT_CYCLES)
            low_run <= low_run + 1;
    end
    chk_parity_flag: assert property (
        channel_parity_error_flag == !(^{bus_in_lines, bus_in_parity})) else $error("parity flag");
    chk_tor_load: assert property (s_wr_tor |=> address_out_tag ==
        !$past(ext_reg_output_bus[8]) && operational_out_tag == !$past(ext_reg_output_bus[11]))
        else $error("tag-out load");
    chk_tor_refuse: assert property (clk_en && write_register_pulse &&
        !ext_reg_group3_select[3] |=> $stable(suppress_out_tag)) else $error("tag-out refuse");
    chk_diag_loop: assert property (diag_loop_active ==
        (ccr_diagnostic && !operational_out_tag && !suppress_out_tag)) else $error("diag loop");
    chk_xmn_set: assert property (clk_en && rank_one_load_strobe && ccr_input_dir &&
        !adapter_selected && channel_parity_error_flag |=> transmission_check) else $error("xmn");
    chk_odd_toggle: assert property (clk_en && byte_transferred && data_transfer_seq &&
        ccr_assembly_mode |=> odd_byte != $past(odd_byte)) else $error("odd toggle");
    chk_hold_lock: assert property (
        s_drop |-> ##[0:1] hold_lockout_busy) else $error("no lockout");
    chk_lockout_len: assert property (
        $rose(hold_out_tag) |-> low_run >= LOCKOUT_CYCLES) else $error("lockout short");
endmodule
bind cbt_channel_bus cbt_chk #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) chk_i (
    .clk(clk), .rst(rst), .clk_en(clk_en), .ext_reg_group3_select(ext_reg_group3_select),
    .write_register_pulse(write_register_pulse), .ext_reg_output_bus(ext_reg_output_bus),
    .ccr_input_dir(ccr_input_dir), .ccr_diagnostic(ccr_diagnostic),
    .ccr_assembly_mode(ccr_assembly_mode), .rank_one_load_strobe(rank_one_load_strobe),
    .data_transfer_seq(data_transfer_seq), .byte_transferred(byte_transferred),
    .bus_in_lines(bus_in_lines), .bus_in_parity(bus_in_parity),
    .adapter_selected(adapter_selected), .address_out_tag(address_out_tag),
    .operational_out_tag(operational_out_tag), .suppress_out_tag(suppress_out_tag),
    .hold_out_tag(hold_out_tag), .diag_loop_active(diag_loop_active),
    .channel_parity_error_flag(channel_parity_error_flag),
    .transmission_check(transmission_check), .odd_byte(odd_byte),
    .hold_lockout_busy(hold_lockout_busy));

// File: sim/cbt_far_end.sv
`timescale 1ns/1ps
module cbt_far_end (
    input wire logic clk,
    input wire logic offer,
    input wire logic [7:0] tx_byte,
    input wire logic bad_par,
    input wire logic hold_out_tag,
    input wire logic card_reader_select_out,
    output logic [7:0] bus_in_lines,
    output logic bus_in_parity,
    output logic card_reader_select_in
);
    logic [7:0] junk = 8'hA5;
    // Released bus shows a changing pattern
    always_ff @(posedge clk) junk <= ~junk;
    assign bus_in_lines = offer ? tx_byte : junk;
    // Odd parity over nine lines unless told to break it
    assign bus_in_parity = ~^tx_byte ^ bad_par;
    // Select passes only while hold is up; a drop clears it
    assign card_reader_select_in = card_reader_select_out & hold_out_tag;
endmodule
